// ==== include/fmove_pkg.sv ====
// Constants and types for the file move instruction decoder
`default_nettype none
package fmove_pkg;
    localparam int unsigned INSN_W = 14;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned ADDR_W = 7;
    localparam int unsigned DEST_BIT = 7;
    localparam int unsigned MOVE_OP_MSB = 13;
    localparam int unsigned MOVE_OP_LSB = 8;
    localparam logic [5:0] MOVE_FILE_OPCODE = 6'h08;
    localparam int unsigned STORE_OP_MSB = 13;
    localparam int unsigned STORE_OP_LSB = 7;
    localparam logic [6:0] STORE_WORKING_OPCODE = 7'h01;
    localparam logic [13:0] IDLE_MASK = 14'h3f9f;
    localparam logic [13:0] IDLE_CODE = 14'h0000;
    localparam logic [7:0] WORKING_RESET = 8'h00;
    localparam logic ZERO_RESET = 1'b0;
    typedef enum logic [1:0] {
        OP_NONE = 2'b00,
        OP_MOVE = 2'b01,
        OP_STORE = 2'b11,
        OP_IDLE = 2'b10
    } op_kind_t;
endpackage : fmove_pkg
`default_nettype wire

// ==== src/fmove_classify.sv ====
// Opcode classifier for the three handled instructions
`default_nettype none
module fmove_classify (
    // Instruction word
    input wire logic [13:0] insn_in,
    // Decoded class
    output fmove_pkg::op_kind_t kind_out
);
    always_comb begin
        if (insn_in[fmove_pkg::MOVE_OP_MSB:fmove_pkg::MOVE_OP_LSB]
                == fmove_pkg::MOVE_FILE_OPCODE) begin
            kind_out = fmove_pkg::OP_MOVE;
        end else if (insn_in[fmove_pkg::STORE_OP_MSB:fmove_pkg::STORE_OP_LSB]
                == fmove_pkg::STORE_WORKING_OPCODE) begin
            kind_out = fmove_pkg::OP_STORE;
        end else if ((insn_in & fmove_pkg::IDLE_MASK)
                == fmove_pkg::IDLE_CODE) begin
            kind_out = fmove_pkg::OP_IDLE;
        end else begin
            kind_out = fmove_pkg::OP_NONE;
        end
    end
endmodule : fmove_classify
`default_nettype wire

// ==== src/file_move_instruction_decode.sv ====
// Decode and execute of move file, store working and idle instructions
`default_nettype none
module file_move_instruction_decode #(
    parameter int unsigned DATA_W = fmove_pkg::DATA_W,
    parameter int unsigned ADDR_W = fmove_pkg::ADDR_W
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Instruction issue, one word per cycle while valid
    input wire logic insn_valid_in,
    input wire logic [13:0] insn_in,
    // File register read port, combinational
    output logic [ADDR_W-1:0] file_raddr_out,
    input wire logic [DATA_W-1:0] file_rdata_in,
    // File register write port
    output logic file_we_out,
    output logic [ADDR_W-1:0] file_waddr_out,
    output logic [DATA_W-1:0] file_wdata_out,
    // Core state
    output logic [DATA_W-1:0] working_out,
    output logic zero_flag_out,
    // Decode status
    output logic handled_out
);
    // Decoded class of the word on the bus
    fmove_pkg::op_kind_t kind;

    // Instruction fields
    logic dest_file;
    logic [ADDR_W-1:0] addr;

    // Decode strobes, each gated by valid
    logic go;
    logic move_go;
    logic move_to_w;
    logic move_to_f;
    logic store_go;
    logic idle_go;
    logic write_go;

    // Zero detect of the read data
    logic [DATA_W:0] any_set;
    logic read_zero;

    // Core state
    logic [DATA_W-1:0] working_r;
    logic zero_r;

    // Write port registers
    logic we_r;
    logic [ADDR_W-1:0] waddr_r;
    logic [DATA_W-1:0] wdata_r;

    // Source of the next write data
    logic [DATA_W-1:0] wsrc;

    fmove_classify u_classify (
        .insn_in(insn_in),
        .kind_out(kind)
    );

    // Field split
    assign dest_file = insn_in[fmove_pkg::DEST_BIT];
    assign addr = insn_in[ADDR_W-1:0];

    // Strobes
    assign go = insn_valid_in;
    assign move_go = go && (kind == fmove_pkg::OP_MOVE);
    assign move_to_w = move_go && !dest_file;
    assign move_to_f = move_go && dest_file;
    assign store_go = go && (kind == fmove_pkg::OP_STORE);
    assign idle_go = go && (kind == fmove_pkg::OP_IDLE);
    assign write_go = move_to_f || store_go;

    // Read port follows the file field
    assign file_raddr_out = addr;

    // One of the three handled instructions
    assign handled_out = move_go || store_go || idle_go;

    // Zero detect, one OR stage per data bit
    assign any_set[0] = 1'b0;
    for (genvar b = 0; b < DATA_W; b++) begin : g_zero
        assign any_set[b+1] = any_set[b] | file_rdata_in[b];
    end
    assign read_zero = !any_set[DATA_W];

    // Write data: file value on write back, working register on store
    always_comb begin
        wsrc = file_rdata_in;
        if (store_go) begin
            wsrc = working_r;
        end
    end

    // Working register, loaded only by a move to working
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            working_r <= fmove_pkg::WORKING_RESET;
        end else if (move_to_w) begin
            working_r <= file_rdata_in;
        end
    end

    // Zero flag, touched by move file only
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            zero_r <= fmove_pkg::ZERO_RESET;
        end else if (move_go) begin
            zero_r <= read_zero;
        end
    end

    // Write strobe, one cycle per writing instruction
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            we_r <= 1'b0;
        end else begin
            we_r <= write_go;
        end
    end

    // Write address, held between writes
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            waddr_r <= '0;
        end else if (write_go) begin
            waddr_r <= addr;
        end
    end

    // Write data, held between writes
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wdata_r <= '0;
        end else if (write_go) begin
            wdata_r <= wsrc;
        end
    end

    // Outputs
    assign file_we_out = we_r;
    assign file_waddr_out = waddr_r;
    assign file_wdata_out = wdata_r;
    assign working_out = working_r;
    assign zero_flag_out = zero_r;
endmodule : file_move_instruction_decode
`default_nettype wire

// ==== verification/fmove_monitor.sv ====
// Assertion checker for the file move decoder
`default_nettype none
module fmove_monitor (
    // Watched ports
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic insn_valid_in,
    input wire logic [13:0] insn_in,
    input wire logic [7:0] file_rdata_in,
    input wire logic [6:0] file_raddr_out,
    input wire logic [6:0] file_waddr_out,
    input wire logic file_we_out,
    input wire logic [7:0] file_wdata_out,
    input wire logic [7:0] working_out,
    input wire logic zero_flag_out,
    input wire logic handled_out
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    logic mv, st, idl;
    assign mv = insn_valid_in && insn_in[13:8] == 6'h08;
    assign st = insn_valid_in && insn_in[13:7] == 7'h01;
    assign idl = insn_valid_in && (insn_in & 14'h3f9f) == 14'h0000;
    sequence s_quiet;
        !file_we_out && $stable(working_out) && $stable(zero_flag_out);
    endsequence
    a_move_to_w: assert property (mv && !insn_in[7] |=>
        working_out == $past(file_rdata_in) && !file_we_out)
        else $error("move to working wrong");
    a_move_back: assert property (mv && insn_in[7] |=>
        file_we_out && file_wdata_out == $past(file_rdata_in)
        && $stable(working_out)) else $error("move back wrong");
    a_zero_upd: assert property (mv |=>
        zero_flag_out == ($past(file_rdata_in) == 8'h00))
        else $error("zero flag wrong");
    a_store_copy: assert property (st |=> file_we_out &&
        file_wdata_out == $past(working_out) && $stable(zero_flag_out))
        else $error("store wrong");
    a_idle_quiet: assert property (!mv && !st |=> s_quiet)
        else $error("state changed without instruction");
    a_decode_ok: assert property (
        handled_out == (mv || st || idl)) else $error("handled flag wrong");
    a_read_addr: assert property (mv |->
        file_raddr_out == insn_in[6:0]) else $error("read address wrong");
    a_write_addr: assert property ((mv && insn_in[7]) || st |=>
        file_waddr_out == $past(insn_in[6:0]))
        else $error("write address wrong");
endmodule : fmove_monitor
bind file_move_instruction_decode fmove_monitor mon (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .insn_valid_in(insn_valid_in),
    .insn_in(insn_in),
    .file_rdata_in(file_rdata_in),
    .file_raddr_out(file_raddr_out),
    .file_waddr_out(file_waddr_out),
    .file_we_out(file_we_out),
    .file_wdata_out(file_wdata_out),
    .working_out(working_out),
    .zero_flag_out(zero_flag_out),
    .handled_out(handled_out)
);
`default_nettype wire

// ==== verification/file_move_instruction_decode_tb.sv ====
// Self-checking bench of the file move decoder
`default_nettype none
module file_move_instruction_decode_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_in = 1'b0, rst_n_in = 1'b0, insn_valid_in = 1'b0, z_e = 1'b0;
    logic [13:0] insn_in = 14'h0000;
    logic [7:0] file_rdata_in = 8'h00, w_e = 8'h00, wd_e, file_wdata_out;
    logic [6:0] wa_e, file_raddr_out, file_waddr_out;
    logic [7:0] working_out;
    logic we_e = 1'b0, file_we_out, zero_flag_out, handled_out;
    logic [13:0] cor [6] = '{14'h0805, 14'h0885, 14'h0085, 14'h0060,
        14'h0000, 14'h08ff};
    int n_errors = 0, checked = 0, cyc = 0;
    file_move_instruction_decode uut (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .insn_valid_in(insn_valid_in),
        .insn_in(insn_in),
        .file_raddr_out(file_raddr_out),
        .file_rdata_in(file_rdata_in),
        .file_we_out(file_we_out),
        .file_waddr_out(file_waddr_out),
        .file_wdata_out(file_wdata_out),
        .working_out(working_out),
        .zero_flag_out(zero_flag_out),
        .handled_out(handled_out)
    );
    always #25 clk_in = ~clk_in;
    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_errors++;
            stop_test();
        end
    end
    function automatic logic [13:0] pick(int unsigned k, logic [13:0] r);
        case (k)
            0: return {6'h08, r[7:0]};
            1: return {7'h01, r[6:0]};
            2: return {7'h00, r[6:5], 5'h00};
            default: return r;
        endcase
    endfunction : pick
    task automatic cmp(string s, logic [7:0] e, logic [7:0] g);
        checked++;
        if (g !== e) begin
            n_errors++;
            $display("BAD %s exp %h got %h", s, e, g);
        end
    endtask : cmp
    task automatic step(logic v, logic [13:0] i, logic [7:0] d);
        logic mv, st;
        @(posedge clk_in);
        insn_valid_in <= v;
        insn_in <= i;
        file_rdata_in <= d;
        #1;
        mv = v && i[13:8] == 6'h08;
        st = v && i[13:7] == 7'h01;
        cmp("we", {7'h00, we_e}, {7'h00, file_we_out});
        cmp("working", w_e, working_out);
        cmp("zero", {7'h00, z_e}, {7'h00, zero_flag_out});
        if (we_e) begin
            cmp("waddr", 8'(wa_e), 8'(file_waddr_out));
            cmp("wdata", wd_e, file_wdata_out);
        end
        cmp("raddr", 8'(i[6:0]), 8'(file_raddr_out));
        cmp("handled", {7'h00, mv | st | v & (i & 14'h3f9f) == 14'h0000},
            {7'h00, handled_out});
        we_e = mv & i[7] | st;
        wa_e = i[6:0];
        wd_e = st ? w_e : d;
        if (mv & !i[7]) w_e = d;
        if (mv) z_e = d == 8'h00;
    endtask : step
    initial begin
        void'($urandom(46));
        repeat (16) @(posedge clk_in);
        rst_n_in <= 1'b1;
        foreach (cor[k]) step(1'b1, cor[k], 8'(k));
        repeat (400) step($urandom_range(3) != 0, pick($urandom_range(3),
            14'($urandom)), $urandom_range(1) ? 8'h00 : 8'($urandom));
        step(1'b0, 14'h0000, 8'h00);
        stop_test();
    end
    task automatic stop_test();
        if (n_errors == 0 && checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : stop_test
endmodule : file_move_instruction_decode_tb
`default_nettype wire
